// *** hw/icpf_pkg.sv ***
// constants and types for the idle colour and pixel format block
package icpf_pkg;

  // =====================================================================
  // command codes, short form (one byte) and 16-bit serial form
  // =====================================================================
  localparam logic [7:0] ICPF_CMD_IDLE_ENTER_B = 8'h39; // idle_enter_cmd
  localparam logic [15:0] ICPF_CMD_IDLE_ENTER_W = 16'h3900;
  localparam logic [7:0] ICPF_CMD_IDLE_EXIT_B = 8'h38; // idle_exit_cmd
  localparam logic [15:0] ICPF_CMD_IDLE_EXIT_W = 16'h3800;
  localparam logic [7:0] ICPF_CMD_PIX_FMT_B = 8'h3a; // pixel_format_cmd
  localparam logic [15:0] ICPF_CMD_PIX_FMT_W = 16'h3a00;

  // =====================================================================
  // interface_pixel_format register
  // =====================================================================
  localparam logic [7:0] ICPF_PIX_FMT_OFFSET = 8'h3a; // command offset
  localparam logic [7:0] ICPF_PIX_FMT_RESET = 8'h70; // 24 bits per pixel
  localparam int ICPF_SEL_LSB = 4; // field rgb_bits_per_pixel_sel lsb
  localparam int ICPF_SEL_MSB = 6; // field msb

  // rgb_bits_per_pixel_sel encodings
  localparam logic [2:0] ICPF_SEL_16BPP = 3'h5;
  localparam logic [2:0] ICPF_SEL_18BPP = 3'h6;
  localparam logic [2:0] ICPF_SEL_24BPP = 3'h7;
  localparam logic [2:0] ICPF_SEL_RESET = 3'h7;

  // =====================================================================
  // buffer and channel sizes
  // =====================================================================
  localparam int ICPF_BUF_DEPTH = 2; // entries in output buffer
  localparam logic [1:0] ICPF_BUF_FULL = 2'h2; // count when full
  localparam logic [7:0] ICPF_CH_ON = 8'hff; // channel fully on
  localparam logic [7:0] ICPF_CH_OFF = 8'h00; // channel fully off

  // command decoder states
  typedef enum logic [0:0] {
    ICPF_ST_CMD,
    ICPF_ST_PARAM
  } icpf_state_e;

endpackage : icpf_pkg

// *** hw/icpf_top.sv ***
// idle colour reduction and interface pixel format for the rgb pixel path
`timescale 1ns/1ps
// Summary of operation
// R1: code 39h or 3900h enters idle, no parameter
// R2: idle-enter command sets reduced colour state
// R3: idle mode uses only each channel msb
// R4: msb one full on, zero full off
// R5: idle-enter while idle changes nothing
// R6: any reset clears idle, full colour
// R7: both commands accepted in every state
// R8: code 3Ah or 3A00h plus one parameter
// R9: stored format decides pixel unpacking
// R10: 101 16bpp, 110 18bpp, 111 24bpp
// R11: format change waits for new frame data
// R12: any reset loads format byte 70h
// R13: code 38h or 3800h leaves idle mode
// R14: format field is bits 6 to 4

module icpf_top
  import icpf_pkg::*;
(
  input wire logic core_clk_i, // 200 mhz core clock
  input wire logic srst_i, // hardware reset, synchronous, active high
  input wire logic sw_reset_i, // software reset pulse from command layer
  input wire logic cmd_valid_i, // command or parameter word present
  input wire logic cmd_is_param_i, // high: parameter byte, low: command code
  input wire logic cmd_spi16_i, // high: 16-bit serial code form
  input wire logic [15:0] cmd_data_i, // parameter and short-form code in low byte, 16-bit code form uses the whole word
  output logic cmd_ready_o, // command path always accepts
  input wire logic pix_valid_i, // incoming pixel word valid
  input wire logic pix_sof_i, // first pixel of newly written frame data
  input wire logic [23:0] pix_data_i, // raw pixel bus
  output logic pix_ready_o, // buffer can take a pixel
  output logic out_valid_o, // converted pixel valid
  input wire logic out_ready_i, // receiver takes pixel
  output logic [7:0] out_red_o, // red channel, 8 bits
  output logic [7:0] out_green_o, // green channel, 8 bits
  output logic [7:0] out_blue_o, // blue channel, 8 bits
  output logic idle_mode_o, // idle colour mode active
  output logic [7:0] pixel_format_o, // stored format byte
  output logic [2:0] active_sel_o // format applied to current frame
);

  // ===================================================================
  // functions
  // ===================================================================

  // match a command in either code form
  function automatic logic cmd_match(input logic spi16, input logic [15:0] data,
                                     input logic [7:0] code_b, input logic [15:0] code_w);
    if (spi16)
    begin
      cmd_match = (data == code_w);
    end
    else
    begin
      cmd_match = (data[7:0] == code_b);
    end
  endfunction : cmd_match

  // widen a 6-bit channel to 8 bits by repeating the top bits
  function automatic logic [7:0] widen6(input logic [5:0] ch);
    widen6 = {ch, ch[5:4]};
  endfunction : widen6

  // widen a 5-bit channel to 8 bits by repeating the top bits
  function automatic logic [7:0] widen5(input logic [4:0] ch);
    widen5 = {ch, ch[4:2]};
  endfunction : widen5

  // collapse a channel to full on or full off from its msb
  function automatic logic [7:0] idle_ch(input logic [7:0] ch);
    if (ch[7])
    begin
      idle_ch = ICPF_CH_ON; // [R4]
    end
    else
    begin
      idle_ch = ICPF_CH_OFF; // [R4]
    end
  endfunction : idle_ch

  // ===================================================================
  // command decoder state
  // ===================================================================
  icpf_state_e state_reg; // waiting for command or parameter
  icpf_state_e state_next;
  logic idle_reg; // idle colour mode flag
  logic idle_next;
  logic [7:0] fmt_reg; // interface_pixel_format byte
  logic [7:0] fmt_next;
  logic is_enter; // idle-enter code seen
  logic is_exit; // idle-exit code seen
  logic is_fmt; // pixel-format code seen

  // decode the command codes in both forms
  always_comb
  begin
    is_enter = cmd_match(cmd_spi16_i, cmd_data_i, ICPF_CMD_IDLE_ENTER_B,
                         ICPF_CMD_IDLE_ENTER_W); // [R1]
    is_exit = cmd_match(cmd_spi16_i, cmd_data_i, ICPF_CMD_IDLE_EXIT_B,
                        ICPF_CMD_IDLE_EXIT_W); // [R13]
    is_fmt = cmd_match(cmd_spi16_i, cmd_data_i, ICPF_CMD_PIX_FMT_B,
                       ICPF_CMD_PIX_FMT_W); // [R8]
  end

  // next values of the command state, accepted regardless of display mode
  always_comb
  begin
    state_next = state_reg;
    idle_next = idle_reg;
    fmt_next = fmt_reg;
    if (sw_reset_i)
    begin
      // software reset restores defaults
      state_next = ICPF_ST_CMD;
      idle_next = 1'b0; // [R6]
      fmt_next = ICPF_PIX_FMT_RESET; // [R12]
    end
    else if (cmd_valid_i && !cmd_is_param_i)
    begin
      // a command code; any code ends a pending parameter wait
      state_next = ICPF_ST_CMD;
      if (is_enter)
      begin
        idle_next = 1'b1; // [R2] [R5] [R7]
      end
      else if (is_exit)
      begin
        idle_next = 1'b0; // [R13] [R7]
      end
      else if (is_fmt)
      begin
        state_next = ICPF_ST_PARAM; // [R8] [R7]
      end
      else
      begin
        // other commands belong to other blocks
        state_next = ICPF_ST_CMD;
      end
    end
    else if (cmd_valid_i && cmd_is_param_i)
    begin
      case (state_reg)
        ICPF_ST_PARAM:
        begin
          // keep only the format field, other bits ignored
          fmt_next = 8'h00;
          fmt_next[ICPF_SEL_MSB:ICPF_SEL_LSB] =
            cmd_data_i[ICPF_SEL_MSB:ICPF_SEL_LSB]; // [R14] [R8]
          state_next = ICPF_ST_CMD;
        end
        default:
        begin
          // stray parameter, ignored
          state_next = ICPF_ST_CMD;
        end
      endcase
    end
  end

  // register the command state
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= ICPF_ST_CMD;
      idle_reg <= 1'b0; // [R6]
      fmt_reg <= ICPF_PIX_FMT_RESET; // [R12]
    end
    else
    begin
      state_reg <= state_next;
      idle_reg <= idle_next;
      fmt_reg <= fmt_next;
    end
  end

  // ===================================================================
  // active format, taken over at the start of new frame data
  // ===================================================================
  logic [2:0] act_reg; // format applied to the frame in flight
  logic [2:0] act_next;
  logic [2:0] stored_sel; // field of the stored byte
  logic [2:0] eff_sel; // format for the pixel now accepted
  logic pix_take; // pixel accepted this cycle

  // pick the format for the incoming pixel
  always_comb
  begin
    stored_sel = fmt_reg[ICPF_SEL_MSB:ICPF_SEL_LSB];
    pix_take = pix_valid_i && pix_ready_o;
    eff_sel = act_reg;
    if (pix_take && pix_sof_i)
    begin
      // undefined codes keep the previous format
      if ((stored_sel == ICPF_SEL_16BPP) || (stored_sel == ICPF_SEL_18BPP) ||
          (stored_sel == ICPF_SEL_24BPP))
      begin
        eff_sel = stored_sel; // [R11] [R9]
      end
    end
    act_next = eff_sel;
    if (sw_reset_i)
    begin
      act_next = ICPF_SEL_RESET; // [R12]
    end
  end

  // register the active format
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      act_reg <= ICPF_SEL_RESET;
    end
    else
    begin
      act_reg <= act_next;
    end
  end

  // ===================================================================
  // pixel unpacking and idle reduction
  // ===================================================================
  logic [7:0] unp_r; // unpacked red
  logic [7:0] unp_g; // unpacked green
  logic [7:0] unp_b; // unpacked blue
  logic [23:0] conv_pix; // converted pixel for the buffer

  // unpack by format, then reduce to eight colours when idle
  always_comb
  begin
    case (eff_sel)
      ICPF_SEL_16BPP:
      begin
        unp_r = widen5(pix_data_i[15:11]); // [R10] [R9]
        unp_g = widen6(pix_data_i[10:5]);
        unp_b = widen5(pix_data_i[4:0]);
      end
      ICPF_SEL_18BPP:
      begin
        unp_r = widen6(pix_data_i[17:12]); // [R10] [R9]
        unp_g = widen6(pix_data_i[11:6]);
        unp_b = widen6(pix_data_i[5:0]);
      end
      default:
      begin
        // 24 bits per pixel
        unp_r = pix_data_i[23:16]; // [R10] [R9]
        unp_g = pix_data_i[15:8];
        unp_b = pix_data_i[7:0];
      end
    endcase
    if (idle_reg)
    begin
      conv_pix = {idle_ch(unp_r), idle_ch(unp_g), idle_ch(unp_b)}; // [R3]
    end
    else
    begin
      conv_pix = {unp_r, unp_g, unp_b}; // [R6]
    end
  end

  // ===================================================================
  // two-entry output buffer
  // ===================================================================
  logic [23:0] buf_reg [ICPF_BUF_DEPTH]; // stored pixels
  logic [23:0] buf_next [ICPF_BUF_DEPTH];
  logic wr_ptr_reg; // write index
  logic wr_ptr_next;
  logic rd_ptr_reg; // read index
  logic rd_ptr_next;
  logic [1:0] cnt_reg; // entries held
  logic [1:0] cnt_next;
  logic pop; // receiver takes head

  // next buffer contents and pointers
  always_comb
  begin
    buf_next = buf_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    pop = out_valid_o && out_ready_i;
    if (pix_take)
    begin
      buf_next[wr_ptr_reg] = conv_pix;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop)
    begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (pix_take && !pop)
    begin
      cnt_next = cnt_reg + 2'h1;
    end
    else if (pop && !pix_take)
    begin
      cnt_next = cnt_reg - 2'h1;
    end
    else
    begin
      cnt_next = cnt_reg;
    end
    if (sw_reset_i)
    begin
      // software reset drops queued pixels
      wr_ptr_next = 1'b0;
      rd_ptr_next = 1'b0;
      cnt_next = 2'h0;
    end
  end

  // register the buffer
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      buf_reg[0] <= 24'h000000;
      buf_reg[1] <= 24'h000000;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      buf_reg <= buf_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // ===================================================================
  // outputs
  // ===================================================================
  assign cmd_ready_o = 1'b1; // [R7]
  assign pix_ready_o = (cnt_reg != ICPF_BUF_FULL) && !sw_reset_i;
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_red_o = buf_reg[rd_ptr_reg][23:16];
  assign out_green_o = buf_reg[rd_ptr_reg][15:8];
  assign out_blue_o = buf_reg[rd_ptr_reg][7:0];
  assign idle_mode_o = idle_reg;
  assign pixel_format_o = fmt_reg;
  assign active_sel_o = act_reg;

endmodule : icpf_top

// *** dv/icpf_checker.sv ***
// assertion checker for the idle colour and pixel format block
`timescale 1ns/1ps
module icpf_checker
  import icpf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic sw_reset_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_is_param_i,
  input wire logic cmd_spi16_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic cmd_ready_o,
  input wire logic pix_valid_i,
  input wire logic pix_sof_i,
  input wire logic [23:0] pix_data_i,
  input wire logic pix_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [7:0] out_red_o,
  input wire logic [7:0] out_green_o,
  input wire logic [7:0] out_blue_o,
  input wire logic idle_mode_o,
  input wire logic [7:0] pixel_format_o,
  input wire logic [2:0] active_sel_o
);
  // ===================================================================
  // decoded strobes
  wire [15:0] cw = cmd_spi16_i ? cmd_data_i : {cmd_data_i[7:0], 8'h00};
  wire cmd_w = cmd_valid_i && !cmd_is_param_i && !sw_reset_i;
  wire acc = pix_valid_i && pix_ready_o && !sw_reset_i && !pix_sof_i && !out_valid_o;
  wire [23:0] rgb = {out_red_o, out_green_o, out_blue_o};
  wire dflt = !idle_mode_o && pixel_format_o == ICPF_PIX_FMT_RESET && !out_valid_o
    && active_sel_o == ICPF_SEL_RESET;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  cmd_rdy_a: assert property (cmd_ready_o) else $error("command path busy");
  idle_on_a: assert property (cmd_w && cw == ICPF_CMD_IDLE_ENTER_W |=> idle_mode_o)
    else $error("idle enter missed");
  idle_off_a: assert property (cmd_w && cw == ICPF_CMD_IDLE_EXIT_W |=> !idle_mode_o)
    else $error("idle exit missed");
  sw_rst_a: assert property (sw_reset_i |=> dflt) else $error("soft reset state");
  hw_rst_a: assert property ($fell(srst_i) |-> dflt) else $error("hard reset state");
  fmt_hold_a: assert property (!cmd_valid_i && !sw_reset_i |=> $stable(pixel_format_o))
    else $error("format moved alone");
  fmt_bits_a: assert property (pixel_format_o[7] == 1'b0 && pixel_format_o[3:0] == 4'h0)
    else $error("format spare bits set");
  sel_hold_a: assert property (!(pix_valid_i && pix_ready_o && pix_sof_i) && !sw_reset_i
    |=> $stable(active_sel_o)) else $error("format applied early");
  out_hold_a: assert property (out_valid_o && !out_ready_i && !sw_reset_i
    |=> out_valid_o && $stable(rgb)) else $error("stalled pixel lost");
  idle_pix_a: assert property (acc && idle_mode_o && active_sel_o == ICPF_SEL_24BPP
    |=> rgb == {{8{$past(pix_data_i[23])}}, {8{$past(pix_data_i[15])}},
    {8{$past(pix_data_i[7])}}})
    else $error("idle colour wrong");
  pass_pix_a: assert property (acc && !idle_mode_o && active_sel_o == ICPF_SEL_24BPP
    |=> rgb == $past(pix_data_i)) else $error("full colour wrong");
  cover property (acc && idle_mode_o);
  cover property (pix_valid_i && !pix_ready_o);
  cover property ($changed(active_sel_o));
  cover property (pix_valid_i && pix_ready_o && active_sel_o == ICPF_SEL_16BPP);
endmodule : icpf_checker
bind icpf_top icpf_checker i_chk (.core_clk_i, .srst_i, .sw_reset_i, .cmd_valid_i, .cmd_is_param_i,
  .cmd_spi16_i, .cmd_data_i, .cmd_ready_o, .pix_valid_i, .pix_sof_i, .pix_data_i, .pix_ready_o,
  .out_valid_o, .out_ready_i, .out_red_o, .out_green_o, .out_blue_o, .idle_mode_o,
  .pixel_format_o, .active_sel_o);

// *** dv/icpf_host_model.sv ***
// host side model: feeds command words and pixel words to the block
`timescale 1ns/1ps
module icpf_host_model (
  input wire logic clk_i,
  input wire logic pix_ready_i,
  output logic cv_o = 1'b0,
  output logic cp_o = 1'b0,
  output logic cs_o = 1'b0,
  output logic [15:0] cd_o = 16'h0000,
  output logic pv_o = 1'b0,
  output logic ps_o = 1'b0,
  output logic [23:0] pd_o = 24'h000000
);
  logic [17:0] cq[$]; // queued command words
  logic [24:0] pq[$]; // queued pixel words with start flag
  // one command word per cycle, data inverted every cycle while no word is queued
  always @(posedge clk_i)
  begin
    if (cq.size() > 0)
      {cv_o, cp_o, cs_o, cd_o} <= {1'b1, cq.pop_front()};
    else
    begin
      cv_o <= 1'b0;
      cd_o <= ~cd_o;
    end
  end
  // pixel word held until the block takes it
  always @(posedge clk_i)
  begin
    if (pv_o && pix_ready_i)
      void'(pq.pop_front());
    if (pq.size() > 0)
      {pv_o, ps_o, pd_o} <= {1'b1, pq[0]};
    else
    begin
      pv_o <= 1'b0;
      pd_o <= ~pd_o;
    end
  end
endmodule : icpf_host_model

// *** dv/testbench.sv ***
// self-checking bench with a reference model of the pixel path
`timescale 1ns/1ps
module testbench;
  import icpf_pkg::*;
  logic core_clk_i = 0, srst_i = 1, sw_reset_i = 0, out_ready_i = 1;
  logic cmd_valid_i, cmd_is_param_i, cmd_spi16_i, pix_valid_i, pix_sof_i;
  logic cmd_ready_o, pix_ready_o, out_valid_o, idle_mode_o;
  logic [15:0] cmd_data_i, cw;
  logic [23:0] pix_data_i;
  logic [7:0] out_red_o, out_green_o, out_blue_o, pixel_format_o, lfsr = 8'h62;
  logic [2:0] active_sel_o;
  logic [2:0] fm[4] = '{3'h7, 3'h3, 3'h6, 3'h5};
  bit hold = 0, rnd = 0, live = 0;
  int n_errors = 0, cmp_count = 0, m_idle, m_fmt, m_sel, m_pend;
  logic [23:0] mq[$]; // expected output pixels
  always #2.5 core_clk_i = ~core_clk_i;
  icpf_top i_dut (.core_clk_i, .srst_i, .sw_reset_i, .cmd_valid_i, .cmd_is_param_i,
    .cmd_spi16_i, .cmd_data_i, .cmd_ready_o, .pix_valid_i, .pix_sof_i, .pix_data_i, .pix_ready_o,
    .out_valid_o, .out_ready_i, .out_red_o, .out_green_o, .out_blue_o, .idle_mode_o,
    .pixel_format_o, .active_sel_o);
  icpf_host_model i_host (.clk_i(core_clk_i), .pix_ready_i(pix_ready_o), .cv_o(cmd_valid_i),
    .cp_o(cmd_is_param_i), .cs_o(cmd_spi16_i), .cd_o(cmd_data_i), .pv_o(pix_valid_i),
    .ps_o(pix_sof_i), .pd_o(pix_data_i));
  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nx
  // widen to 8 bits per channel, then keep only the msb when idle
  function automatic logic [23:0] conv(input int sel, input int idle, input logic [23:0] d);
    if (sel == 6)
      d = {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
    else if (sel == 5)
      d = {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
    if (idle != 0)
      d = {{8{d[23]}}, {8{d[15]}}, {8{d[7]}}};
    return d;
  endfunction : conv
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
      $display("ERROR %s expected %h seen %h", nm, e, g);
    if (g !== e)
      n_errors++;
  endtask : chk
  task automatic cmd(input logic p, input logic s, input logic [7:0] c);
    i_host.cq.push_back({p, s, s ? {c, 8'h00} : {lfsr, c}});
  endtask : cmd
  task automatic px(input int n, input logic sof);
    logic [7:0] x;
    x = lfsr;
    for (int k = 0; k < n; k++)
    begin
      x = nx(nx(x));
      i_host.pq.push_back({sof && k == 0, x, nx(x), ~x});
    end
  endtask : px
  // wait on falling edges, where outputs have settled, until both paths are idle
  task automatic settle;
    int k;
    k = 0;
    @(negedge core_clk_i);
    while (k < 300 && (i_host.pq.size() > 0 || i_host.cq.size() > 0 || pix_valid_i || cmd_valid_i
        || out_valid_o))
    begin
      k++;
      @(negedge core_clk_i);
    end
    if (k == 300)
    begin
      $display("ERROR settle expected idle seen busy");
      n_errors++;
    end
    @(posedge core_clk_i);
  endtask : settle
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // reference model, receiver stall and per-cycle comparison
  always @(posedge core_clk_i)
  begin
    lfsr <= nx(lfsr);
    out_ready_i <= !hold && (!rnd || lfsr[0]);
    if (live)
    begin
      chk("idle_mode_o", m_idle, idle_mode_o);
      chk("pixel_format_o", m_fmt, pixel_format_o);
      chk("active_sel_o", m_sel, active_sel_o);
      chk("cmd_ready_o", 1, cmd_ready_o);
      chk("pix_ready_o", mq.size() < 2 && !sw_reset_i, pix_ready_o);
      chk("out_valid_o", mq.size() != 0, out_valid_o);
      if (out_valid_o && out_ready_i)
        chk("pixel", mq.pop_front(), {out_red_o, out_green_o, out_blue_o});
    end
    if (srst_i || sw_reset_i)
    begin
      m_idle = 0;
      m_fmt = 'h70;
      m_sel = 7;
      m_pend = 0;
      mq = {};
    end
    else
    begin
      cw = cmd_spi16_i ? cmd_data_i : {cmd_data_i[7:0], 8'h00};
      if (pix_valid_i && pix_ready_o && pix_sof_i && m_fmt[6:4] >= 5)
        m_sel = m_fmt[6:4];
      if (pix_valid_i && pix_ready_o)
        mq.push_back(conv(m_sel, m_idle, pix_data_i));
      if (cmd_valid_i && cmd_is_param_i && m_pend != 0)
        m_fmt = cmd_data_i[7:0] & 8'h70;
      if (cmd_valid_i && !cmd_is_param_i && cw == ICPF_CMD_IDLE_ENTER_W)
        m_idle = 1;
      if (cmd_valid_i && !cmd_is_param_i && cw == ICPF_CMD_IDLE_EXIT_W)
        m_idle = 0;
      if (cmd_valid_i)
        m_pend = !cmd_is_param_i && cw == ICPF_CMD_PIX_FMT_W;
    end
  end
  initial
  begin
    #50000;
    n_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    srst_i <= 0;
    live <= 1;
    px(1, 0);
    settle;
    for (int i = 0; i < 6; i++)
    begin
      cmd(0, i[0], i < 4 ? 8'h39 : 8'h38);
      px(1, 0);
      settle;
    end
    $display("test idle colour done");
    cmd(1, 0, 8'h50);
    for (int i = 0; i < 4; i++)
    begin
      cmd(0, i[0], ICPF_CMD_PIX_FMT_B);
      cmd(1, 0, {lfsr[7], fm[i], lfsr[3:0]});
      if (i == 2)
        cmd(0, 0, ICPF_CMD_IDLE_ENTER_B);
      if (i == 3)
        cmd(0, 1, ICPF_CMD_IDLE_EXIT_B);
      settle;
      px(1, 0);
      px(4, 1);
      rnd <= i[0];
      settle;
    end
    $display("test pixel formats done");
    hold <= 1;
    px(6, 1);
    repeat (6) @(posedge core_clk_i);
    sw_reset_i <= 1;
    @(posedge core_clk_i);
    sw_reset_i <= 0;
    hold <= 0;
    rnd <= 1;
    settle;
    srst_i <= 1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 0;
    px(3, 1);
    settle;
    $display("test stall and resets done");
    report_and_stop;
  end
endmodule : testbench
